// File: rtl/sesr_top.sv
// Behaviour
// - Event register bits 8 to 15 always read as zero.
// - Bit 7 set after a power cycle since the last read.
// - User request bit 6 is never set.
// - Bit 5 set on syntax, unknown command or trigger-inside-message error.
// - Bit 4 set on out-of-range parameter or unexecutable valid command.
// - Bit 3 set on device dependent internal failure.
// - Bit 2 set on read of empty output queue or lost data.
// - Bit 1 set while requesting to become active controller.
// - Bit 0 set only when operation-complete command finishes pending work.
// - Reading the event register or clear-status clears every bit that is not set again in the same cycle.
// - Event enable mask written with an integer, readable, zero clears it.
// - Eight-bit status byte holds group and output queue summaries.
// - Service request raised from status byte contents.
// - Eight-bit service request mask gates each summary bit.
// - Status bit 5 true when any enabled event bit is set.
// - Bit 6 master summary is OR of enabled other bits.
// - Serial poll clears request-service bit only, others unchanged.
module sesr_top
  import sesr_pkg::*;
(
  input  wire logic        core_clk,       // 25 MHz core clock
  input  wire logic        resetn,         // Async reset, active low
  input  wire logic        opc_cmd,        // Operation-complete command seen
  input  wire logic        ops_idle,       // No selected operation pending
  input  wire logic        req_control,    // Asking to take bus control
  input  wire logic        syntax_err,     // Message broke syntax
  input  wire logic        unknown_cmd,    // Unrecognised command
  input  wire logic        trig_in_msg,    // Trigger inside program message
  input  wire logic        param_err,      // Parameter out of range
  input  wire logic        exec_blocked,   // Valid command could not run
  input  wire logic        device_err,     // Internal operation failed
  input  wire logic        queue_empty_rd, // Read of empty output queue
  input  wire logic        queue_lost,     // Output data lost
  input  wire logic [7:0]  summary_in,     // Other group summaries and queue
  input  wire logic        cls_cmd,        // Clear-status command
  input  wire logic        reg_rd,         // Register query pulse
  input  wire logic        reg_wr,         // Register write pulse
  input  wire logic [1:0]  reg_sel,        // Register selected
  input  wire logic [7:0]  reg_wdata,      // Write integer
  input  wire logic        spoll,          // Serial poll pulse
  output logic      [15:0] reg_rdata,      // Query answer
  output logic             reg_rvalid,     // Answer valid pulse
  output logic      [7:0]  spoll_byte,     // Serial poll response
  output logic             srq             // Service request to bus
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Standard event register
  // ---------------------------------------------------------------
  sesr_evt_if evt ();
  logic [7:0] next_set;
  logic       opc_armed;
  logic       rd_event;

  assign rd_event = reg_rd && (reg_sel == SEL_EVENT);

  // Operation complete waits for the pending work to drain
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      opc_armed <= 1'b0;
    else if (opc_cmd && !ops_idle)
      opc_armed <= 1'b1;
    else if (ops_idle)
      opc_armed <= 1'b0;
  end

  always_comb
  begin
    next_set = 8'h00;
    next_set[EV_OPC] = ops_idle && (opc_cmd || opc_armed);
    next_set[EV_RQC] = req_control;
    next_set[EV_QYE] = queue_empty_rd || queue_lost;
    next_set[EV_DDE] = device_err;
    next_set[EV_EXE] = param_err || exec_blocked;
    next_set[EV_CME] = syntax_err || unknown_cmd || trig_in_msg;
    next_set[EV_URQ] = 1'b0;
    // Power-on comes only from the reset value
    next_set[EV_PON] = 1'b0;
  end

  assign evt.set_pulse = next_set;
  assign evt.clear_all = rd_event || cls_cmd;

  sesr_event_latch u_latch
  (
    .clk   (core_clk),
    .rst_n (rst_n),
    .evt   (evt)
  );

  // ---------------------------------------------------------------
  // Enable masks
  // ---------------------------------------------------------------
  logic [7:0] event_mask;
  logic [7:0] service_request_mask;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      event_mask <= EVENT_MASK_RST;
    else if (reg_wr && reg_sel == SEL_EMASK)
      event_mask <= reg_wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      service_request_mask <= SRQ_MASK_RST;
    else if (reg_wr && reg_sel == SEL_SRQM)
      service_request_mask <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Status byte
  // ---------------------------------------------------------------
  logic [7:0] summary_status_byte;
  logic       mss;
  logic       rqs;

  always_comb
  begin
    summary_status_byte = summary_in;
    summary_status_byte[SB_ESB] = |(evt.flags & event_mask);
    summary_status_byte[SB_MSS] = 1'b0;
  end

  assign mss = |(summary_status_byte & service_request_mask);

  // Request service latches on a new rise of the master summary
  logic mss_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mss_q <= 1'b0;
    else
      mss_q <= mss;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rqs <= 1'b0;
    else if (mss && !mss_q)
      rqs <= 1'b1;
    else if (spoll || !mss)
      rqs <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      srq <= 1'b0;
    else
      srq <= rqs && !spoll;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      spoll_byte <= 8'h00;
    else if (spoll)
    begin
      spoll_byte         <= summary_status_byte;
      spoll_byte[SB_MSS] <= rqs;
    end
  end

  // ---------------------------------------------------------------
  // Query answers
  // ---------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_sel)
      SEL_EVENT:  next_rdata = {8'h00, evt.flags};
      SEL_EMASK:  next_rdata = {8'h00, event_mask};
      SEL_STATUS: next_rdata = {8'h00, summary_status_byte | {1'b0, mss, 6'h00}};
      SEL_SRQM:   next_rdata = {8'h00, service_request_mask};
      default:    next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

endmodule

// File: rtl/sesr_pkg.sv
package sesr_pkg;

  // ---------------------------------------------------------------
  // Event bit positions
  // ---------------------------------------------------------------
  localparam int EV_OPC  = 0;
  localparam int EV_RQC  = 1;
  localparam int EV_QYE  = 2;
  localparam int EV_DDE  = 3;
  localparam int EV_EXE  = 4;
  localparam int EV_CME  = 5;
  localparam int EV_URQ  = 6;
  localparam int EV_PON  = 7;

  // ---------------------------------------------------------------
  // Status byte bit positions
  // ---------------------------------------------------------------
  localparam int SB_ESB  = 5;
  localparam int SB_MSS  = 6;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int EVENT_WIDTH = 16;
  localparam int BYTE_WIDTH  = 8;
  localparam logic [7:0] EVENT_RESET     = 8'h80;
  localparam logic [7:0] EVENT_MASK_RST  = 8'h00;
  localparam logic [7:0] SRQ_MASK_RST    = 8'h00;

  // ---------------------------------------------------------------
  // Register select codes on the command port
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEL_EVENT  = 2'b00,
    SEL_EMASK  = 2'b01,
    SEL_STATUS = 2'b10,
    SEL_SRQM   = 2'b11
  } sesr_sel_type;

endpackage

// File: rtl/sesr_evt_if.sv
interface sesr_evt_if;
  import sesr_pkg::*;
  logic [7:0] set_pulse;
  logic       clear_all;
  logic [7:0] flags;

  modport owner (input set_pulse, input clear_all, output flags);
  modport user  (output set_pulse, output clear_all, input flags);
endinterface

// File: rtl/sesr_event_latch.sv
module sesr_event_latch
  import sesr_pkg::*;
(
  input  wire logic   clk,     // Core clock
  input  wire logic   rst_n,   // Synchronised reset
  sesr_evt_if.owner   evt      // Event set and clear
);

  // ---------------------------------------------------------------
  // Sticky event bits
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < BYTE_WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          evt.flags[i] <= EVENT_RESET[i];
        else if (evt.set_pulse[i])
          evt.flags[i] <= 1'b1;
        else if (evt.clear_all)
          evt.flags[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// File: verif/sesr_chk.sv
module sesr_chk
  import sesr_pkg::*;
(
  input wire logic        core_clk,    // Clock
  input wire logic        resetn,      // Reset
  input wire logic        reg_rd,      // Query
  input wire logic        reg_wr,      // Write
  input wire logic [1:0]  reg_sel,     // Select
  input wire logic [7:0]  reg_wdata,   // Write data
  input wire logic [15:0] reg_rdata,   // Answer
  input wire logic        reg_rvalid,  // Answer valid
  input wire logic        param_err,   // Exec error
  input wire logic        syntax_err,  // Cmd error
  input wire logic        req_control, // Control
  input wire logic        cls_cmd,     // Clear
  input wire logic        spoll,       // Poll
  input wire logic        srq          // Request
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence calm;
    !reg_rd && !reg_wr && !cls_cmd;
  endsequence
  sequence ev_rd;
    reg_rd && reg_sel == SEL_EVENT;
  endsequence
  sequence mk_wr;
    reg_wr && reg_sel == SEL_EMASK;
  endsequence
  AST_RD_LAT: assert property (reg_rd |=> reg_rvalid)
    else $error("query answer late");
  AST_UPPER: assert property (reg_rvalid |-> reg_rdata[15:8] == 8'h00)
    else $error("upper bits set");
  AST_NO_URQ: assert property (ev_rd |=> !reg_rdata[EV_URQ])
    else $error("user request bit set");
  AST_EXE: assert property (param_err ##1 calm ##1 ev_rd |=> reg_rdata[EV_EXE])
    else $error("exec flag lost");
  AST_CME: assert property (syntax_err ##1 calm ##1 ev_rd |=> reg_rdata[EV_CME])
    else $error("cmd flag lost");
  AST_RQC: assert property (req_control ##1 calm ##1 ev_rd |=> reg_rdata[EV_RQC])
    else $error("control flag lost");
  AST_MASK: assert property (mk_wr ##1 calm ##1 (reg_rd && reg_sel == SEL_EMASK)
    |=> reg_rdata == {8'h00, $past(reg_wdata, 3)})
    else $error("mask readback wrong");
  AST_POLL: assert property (spoll |=> !srq)
    else $error("request kept after poll");
endmodule
bind sesr_top sesr_chk sesr_chk_inst (.core_clk, .resetn, .reg_rd, .reg_wr, .reg_sel, .reg_wdata,
  .reg_rdata, .reg_rvalid, .param_err, .syntax_err, .req_control, .cls_cmd, .spoll, .srq);

// File: verif/sesr_ctl_model.sv
module sesr_ctl_model
(
  input  wire logic clk,   // Clock
  input  wire logic en,    // Polling allowed
  input  wire logic srq,   // Request
  output logic      spoll, // Poll pulse
  output int        polls  // Polls made
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hit;
  // Decide at the rising edge, where request and enable are settled
  // Never two polls in a row: the request needs an edge to drop
  initial
  begin
    spoll = 1'b0;
    polls = 0;
    hit   = 1'b0;
    forever
    begin
      @(posedge clk);
      hit = en && srq && !spoll;
      @(negedge clk);
      spoll <= hit;
      if (hit)
        polls <= polls + 1;
    end
  end
endmodule

// File: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sesr_pkg::*;
  logic        core_clk = 0;
  logic        resetn = 0;
  logic [9:0]  ev = '0;
  logic        ops_idle = 1, cls_cmd = 0, reg_rd = 0, reg_wr = 0, pen = 0;
  logic        spoll, srq, reg_rvalid;
  logic [1:0]  reg_sel = 0;
  logic [7:0]  reg_wdata = 0, summary_in = 0, spoll_byte;
  logic [15:0] reg_rdata, fl = 16'h0080, em = 0, sm = 0;
  int          err_total = 0, num_checks = 0, seed = 39, polls;
  int          map[10] = '{0, 1, 2, 3, 4, 5, 5, 5, 4, 2};
  always #20 core_clk = ~core_clk;
  sesr_top sesr_top_inst (.core_clk, .resetn, .opc_cmd(ev[0]), .ops_idle, .req_control(ev[1]),
    .syntax_err(ev[5]), .unknown_cmd(ev[6]), .trig_in_msg(ev[7]), .param_err(ev[4]),
    .exec_blocked(ev[8]), .device_err(ev[3]), .queue_empty_rd(ev[2]), .queue_lost(ev[9]),
    .summary_in, .cls_cmd, .reg_rd, .reg_wr, .reg_sel, .reg_wdata, .spoll, .reg_rdata,
    .reg_rvalid, .spoll_byte, .srq);
  sesr_ctl_model sesr_ctl_model_inst (.clk(core_clk), .en(pen), .srq, .spoll, .polls);
  task end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  // Tasks rd, wr and pulse start at a falling edge and end with one idle cycle
  task rd(input logic [1:0] s, input logic [15:0] e);
    reg_rd = 1;
    reg_sel = s;
    @(negedge core_clk);
    reg_rd = 0;
    chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    chk("rdata", e, reg_rdata);
    @(negedge core_clk);
  endtask
  task wr(input logic [1:0] s, input logic [7:0] d);
    reg_wr = 1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 0;
    if (s == SEL_EMASK) em = {8'h00, d};
    if (s == SEL_SRQM) sm = {8'h00, d};
    @(negedge core_clk);
  endtask
  task pulse(input int i);
    ev = 10'h001 << i;
    @(negedge core_clk);
    ev = '0;
    fl[map[i]] = 1'b1;
    @(negedge core_clk);
  endtask
  function automatic logic [15:0] sb();
    logic [7:0] b;
    b = summary_in & 8'h9F;
    b[5] = |(fl[7:0] & em[7:0]);
    b[6] = |(b & sm[7:0]);
    return {8'h00, b};
  endfunction
  initial
  begin
    repeat (5) @(negedge core_clk);
    resetn = 1;
    repeat (3) @(negedge core_clk);
    rd(SEL_EVENT, fl);
    fl = 0;
    rd(SEL_EVENT, fl);
    for (int i = 0; i < 10; i++)
    begin
      pulse(i);
      rd(SEL_EVENT, fl);
      fl = 0;
    end
    ops_idle = 0;
    pulse(0);
    fl = 0;
    rd(SEL_EVENT, fl);
    ops_idle = 1;
    repeat (2) @(negedge core_clk);
    fl = 16'h0001;
    rd(SEL_EVENT, fl);
    fl = 0;
    wr(SEL_EMASK, 8'h10);
    rd(SEL_EMASK, em);
    wr(SEL_SRQM, 8'h20);
    pulse(4);
    // Request stands two edges after the summary rises
    @(negedge core_clk);
    chk("srq", 16'h0001, {15'h0000, srq});
    pen = 1;
    for (int k = 0; k < 20 && polls == 0; k++) @(negedge core_clk);
    pen = 0;
    if (polls == 0) err_total++;
    if (polls == 0) end_sim();
    chk("rqs", 16'h0001, {15'h0000, spoll_byte[6]});
    chk("spoll_byte", sb() | 16'h0040, {8'h00, spoll_byte});
    chk("srq", 16'h0000, {15'h0000, srq});
    rd(SEL_STATUS, sb());
    chk("srq", 16'h0000, {15'h0000, srq});
    rd(SEL_EVENT, fl);
    fl = 0;
    wr(SEL_EMASK, 8'h00);
    rd(SEL_EMASK, em);
    repeat (20)
    begin
      wr(2'($random(seed)), 8'($random(seed)));
      pulse($unsigned($random(seed)) % 10);
      summary_in = 8'($random(seed));
      wr(SEL_SRQM, 8'($random(seed)));
      rd(SEL_STATUS, sb());
      rd(SEL_EMASK, em);
      rd(SEL_SRQM, sm);
      if ($random(seed) & 1)
      begin
        cls_cmd = 1;
        @(negedge core_clk);
        cls_cmd = 0;
        fl = 0;
        @(negedge core_clk);
      end
      rd(SEL_EVENT, fl);
      fl = 0;
    end
    end_sim();
  end
endmodule
